//--- sms_core.v
// Serial master/slave core: registers, shifter, pins and flags
// Functional notes
// RL1 - Master-select bit picks master; clear means slave with clock pin as input.
// RL2 - Only master starts, on data write; empty shifter loads at once, sets empty flag.
// RL3 - Two-bit rate select drives master baud generator, hence slave's shift rate.
// RL4 - Each transfer shifts out and in simultaneously, both directions.
// RL5 - End of master transfer sets receiver-full and loads receive register.
// RL6 - Receiver-full clears after status read then data read.
// RL7 - Data write clears transmitter-empty; set again when byte enters shifter.
// RL8 - Remote master holds select low throughout each transfer.
// RL9 - Slave: full byte moves to receive register, sets receiver-full.
// RL10 - Slave accepts any serial clock up to bus clock rate; the edge detect here handles only up to half bus rate.
// RL11 - Slave software writes next byte before transfer, else old byte repeats.
// RL12 - Byte written mid-transfer waits in buffer until transfer ends.
// RL13 - Slave start: first clock edge if phase 1, select fall if phase 0.
// RL14 - Clock line idles correctly before the slave is enabled.
// RL15 - Slave drives its data output only while select is low.
// RL16 - All four polarity and phase combinations supported.
// RL17 - Software disables block before changing polarity or phase.
// RL18 - Phase 0: first edge captures MSB, so MSB presented beforehand.
// RL19 - Phase 0: master toggles select high between bytes.
// RL20 - Master's own select pin held high or reassigned.
// RL21 - Software configures roles first, enables master before slave.
// RL22 - Master uses select line to detect multi-master contention.
// RL23 - Unread receive data at bit-1 capture sets overflow, drops new byte.
// RL24 - Phase 1: master drives data from first edge; select may stay low.
// RL25 - Master start delay from data write at most one bit time.
// RL26 - One error enable gates both overflow and mode-fault requests.
// RL27 - Eight bits per transfer, MSB first.
// RL28 - Interrupts from receiver-full and transmitter-empty with their enables.
`timescale 1ns/10ps
`include "sms_defs.vh"
module sms_core #(
  parameter ADDR_W = `SMS_ADDR_W
) (
  input  wire              clk_in,
  input  wire              sys_rst_in,
  input  wire [ADDR_W-1:0] addr_in,
  input  wire              wr_en_in,
  input  wire              rd_en_in,
  input  wire [7:0]        wdata_in,
  output reg  [7:0]        rdata_out,
  input  wire              sclk_in,
  output reg               sclk_out,
  output reg               sclk_oe_out,
  input  wire              mosi_in,
  output reg               mosi_out,
  output reg               mosi_oe_out,
  input  wire              miso_in,
  output reg               miso_out,
  output reg               miso_oe_out,
  input  wire              ss_n_in,
  output reg               rx_irq_out,
  output reg               err_irq_out
);
  localparam ST_IDLE = 3'b001;
  localparam ST_LEAD = 3'b010;
  localparam ST_SHFT = 3'b100;

  reg [7:0] ctrl_q;
  reg [1:0] rate_q;
  reg       error_interrupt_enable_q;
  reg       modfen_q;
  reg       rxf_q;
  reg       txe_q;
  reg       ovr_q;
  reg       mode_fault_flag_q;
  reg       stat_rd_q;
  reg [7:0] tx_buf_q;
  reg       tx_pend_q;
  reg [7:0] rx_buf_q;
  reg [7:0] sh_q;
  reg       samp_q;
  reg [3:0] cnt_q;
  reg       phase_q;
  reg [2:0] state_q;
  reg       sck_lvl_q;
  reg       sclk_d1_q;
  reg       ss_d1_q;
  reg       m_smp_q;
  reg       m_last_q;
  reg [7:0] m_rx_q;

  wire master   = ctrl_q[`SMS_CTL_MSTR];   // see RL1
  wire enable   = ctrl_q[`SMS_CTL_ENA];
  wire clock_polarity_bit     = ctrl_q[`SMS_CTL_CLOCK_POLARITY_BIT];   // see RL16
  wire clock_phase_bit     = ctrl_q[`SMS_CTL_CLOCK_PHASE_BIT];   // see RL16
  wire wr_ctrl  = wr_en_in && (addr_in == `SMS_ADDR_CTRL);
  wire wr_stat  = wr_en_in && (addr_in == `SMS_ADDR_STAT);
  wire wr_data  = wr_en_in && (addr_in == `SMS_ADDR_DATA);
  wire rd_stat  = rd_en_in && (addr_in == `SMS_ADDR_STAT);
  wire rd_data  = rd_en_in && (addr_in == `SMS_ADDR_DATA);
  wire half_tick;

  // Baud generator only in master mode with enable set
  sms_rate_gen #(
    .CNT_W (7)
  ) u_rate (
    .clk_in        (clk_in),
    .sys_rst_in    (sys_rst_in),
    .run_in        (master && enable),
    .rate_in       (rate_q),            // see RL3
    .half_tick_out (half_tick)
  );

  // Slave edges from synchronous inputs; one-cycle detect keeps up to half bus rate
  wire sl_sel   = enable && !master && !ss_n_in;
  wire sl_lead  = sl_sel && (sclk_in != sclk_d1_q) && (sclk_d1_q == clock_polarity_bit);  // see RL10
  wire sl_trail = sl_sel && (sclk_in != sclk_d1_q) && (sclk_d1_q != clock_polarity_bit);
  wire ss_fall  = enable && !master && ss_d1_q && !ss_n_in;

  // Sample edge is leading edge for phase 0, trailing for phase 1
  wire m_lead   = master && half_tick && (state_q == ST_SHFT) && !phase_q;
  wire m_trail  = master && half_tick && (state_q == ST_SHFT) && phase_q;
  wire smp_ev   = master ? (clock_phase_bit ? m_trail : m_lead) : (clock_phase_bit ? sl_trail : sl_lead);
  wire drv_ev   = master ? (clock_phase_bit ? m_lead : m_trail) : (clock_phase_bit ? sl_lead : sl_trail);
  wire byte_end = smp_ev && (cnt_q == `SMS_BITS - 4'h1);
  wire mode_fault_flag_ev  = master && enable && modfen_q && !ss_n_in;             // see RL22

  function [7:0] load_tx;
    input pend;
    input [7:0] buf_v;
    input [7:0] sh_v;
    begin
      load_tx = pend ? buf_v : sh_v;       // see RL11
    end
  endfunction

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      ctrl_q    <= `SMS_CTL_RST;
      rate_q    <= 2'b00;
      error_interrupt_enable_q   <= 1'b0;
      modfen_q  <= 1'b0;
      rxf_q     <= 1'b0;
      txe_q     <= 1'b1;
      ovr_q     <= 1'b0;
      mode_fault_flag_q    <= 1'b0;
      stat_rd_q <= 1'b0;
      tx_buf_q  <= 8'h00;
      tx_pend_q <= 1'b0;
      rx_buf_q  <= 8'h00;
      sh_q      <= 8'h00;
      samp_q    <= 1'b0;
      cnt_q     <= 4'h0;
      phase_q   <= 1'b0;
      state_q   <= ST_IDLE;
      sck_lvl_q <= 1'b0;
      sclk_d1_q <= 1'b0;
      ss_d1_q   <= 1'b1;
      m_smp_q   <= 1'b0;
      m_last_q  <= 1'b0;
      m_rx_q    <= 8'h00;
    end else begin
      sclk_d1_q <= sclk_in;
      ss_d1_q   <= ss_n_in;
      // Pin clock lags the internal edge by a cycle, so capture one cycle late
      m_smp_q   <= smp_ev && master;
      m_last_q  <= byte_end && master;
      if (m_smp_q) begin
        m_rx_q <= {m_rx_q[6:0], miso_in};  // see RL4
      end
      if (wr_ctrl) begin
        ctrl_q <= wdata_in & `SMS_CTL_MASK;
      end
      if (wr_stat) begin
        error_interrupt_enable_q  <= wdata_in[`SMS_ST_ERROR_INTERRUPT_ENABLE];
        modfen_q <= wdata_in[`SMS_ST_MODFEN];
        rate_q   <= wdata_in[`SMS_ST_RATE_HI:`SMS_ST_RATE_LO];
      end
      // Two-step clear; a new set in the same cycle wins below
      if (rd_stat) begin
        stat_rd_q <= 1'b1;
      end else if (rd_data) begin
        stat_rd_q <= 1'b0;
      end
      if (rd_data && stat_rd_q) begin
        rxf_q <= 1'b0;                    // see RL6
        if (!rxf_q || !master) begin
          ovr_q <= ovr_q;
        end
        if (ovr_q) begin
          ovr_q <= 1'b0;
        end
      end
      if (rd_stat && mode_fault_flag_q && !mode_fault_flag_ev) begin
        mode_fault_flag_q <= 1'b0;
      end
      if (mode_fault_flag_ev) begin
        mode_fault_flag_q <= 1'b1;
      end
      if (wr_data) begin
        tx_buf_q  <= wdata_in;
        tx_pend_q <= 1'b1;
        txe_q     <= 1'b0;                // see RL7
      end
      case (state_q)
        ST_IDLE: begin
          sck_lvl_q <= clock_polarity_bit;
          cnt_q     <= 4'h0;
          phase_q   <= 1'b0;
          if (master && enable && (tx_pend_q || wr_data)) begin
            // Move straight to the shifter when it is empty
            sh_q      <= wr_data ? wdata_in : tx_buf_q;  // see RL2
            tx_pend_q <= 1'b0;
            txe_q     <= 1'b1;                            // see RL7
            state_q   <= ST_LEAD;
          end else if ((clock_phase_bit ? sl_lead : ss_fall) && enable && !master) begin
            sh_q      <= load_tx(tx_pend_q, tx_buf_q, sh_q);  // see RL13
            tx_pend_q <= 1'b0;
            txe_q     <= 1'b1;
            state_q   <= ST_SHFT;
          end
        end
        ST_LEAD: begin
          // Wait for the free-running tick, at most one bit time
          if (half_tick) begin
            state_q <= ST_SHFT;           // see RL25
          end
        end
        ST_SHFT: begin
          if (master && half_tick) begin
            phase_q   <= !phase_q;
            sck_lvl_q <= !sck_lvl_q;      // see RL3
          end
          if (smp_ev) begin
            samp_q <= master ? miso_in : mosi_in;  // see RL4
            cnt_q  <= cnt_q + 4'h1;
            if (cnt_q == 4'h1 && rxf_q) begin
              ovr_q <= 1'b1;              // see RL23
            end
          end
          // Phase 1 first leading edge only presents the MSB
          if (drv_ev && !(clock_phase_bit && cnt_q == 4'h0)) begin
            sh_q <= {sh_q[6:0], samp_q};  // see RL27
          end
          if (byte_end) begin
            // Receive byte lands as the last bit is sampled
            if (!master && !ovr_q) begin
              rx_buf_q <= {sh_q[6:0], mosi_in};  // see RL9
              rxf_q    <= 1'b1;                  // see RL9
            end
            // Idle state returns the clock, so a phase 0 last pulse completes
            state_q <= ST_IDLE;           // see RL12
          end
          if (!enable || (!master && ss_n_in)) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
      if (m_last_q && !ovr_q) begin
        rx_buf_q <= {m_rx_q[6:0], miso_in};  // see RL5
        rxf_q    <= 1'b1;                    // see RL5
      end
      if (!enable) begin
        ovr_q <= ovr_q;
      end
    end
  end

  // Registered pins and read data
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      rdata_out   <= 8'h00;
      sclk_out    <= 1'b0;
      sclk_oe_out <= 1'b0;
      mosi_out    <= 1'b0;
      mosi_oe_out <= 1'b0;
      miso_out    <= 1'b0;
      miso_oe_out <= 1'b0;
      rx_irq_out  <= 1'b0;
      err_irq_out <= 1'b0;
    end else begin
      case (addr_in)
        `SMS_ADDR_CTRL: rdata_out <= ctrl_q;
        `SMS_ADDR_STAT: rdata_out <= {rxf_q, error_interrupt_enable_q, ovr_q, mode_fault_flag_q, txe_q, modfen_q, rate_q};
        `SMS_ADDR_DATA: rdata_out <= rx_buf_q;
        default:        rdata_out <= 8'h00;
      endcase
      sclk_out    <= sck_lvl_q;
      sclk_oe_out <= master && enable;    // see RL1
      mosi_out    <= sh_q[7];             // see RL18
      mosi_oe_out <= master && enable;    // see RL24
      miso_out    <= sh_q[7];             // see RL18
      miso_oe_out <= sl_sel;              // see RL15
      rx_irq_out  <= (rxf_q && ctrl_q[`SMS_CTL_RXIE]) ||
                     (txe_q && ctrl_q[`SMS_CTL_TXIE]);        // see RL28
      err_irq_out <= error_interrupt_enable_q && (ovr_q || mode_fault_flag_q);           // see RL26
    end
  end
endmodule // sms_core

//--- sms_core_test.sv
// Self-checking bench for the serial master/slave core
`timescale 1ns/10ps
`include "sms_defs.vh"
module sms_core_test;
  localparam [7:0] A_CTL = `SMS_ADDR_CTRL;
  localparam [7:0] A_ST  = `SMS_ADDR_STAT;
  localparam [7:0] A_DAT = `SMS_ADDR_DATA;
  reg        clk_in  = 1'b0;
  reg        rst_q   = 1'b1;
  reg  [7:0] addr_q  = 8'h00;
  reg        wr_q    = 1'b0;
  reg        rd_q    = 1'b0;
  reg  [7:0] wdata_q = 8'h00;
  reg        bsclk_q = 1'b0;
  reg        bmosi_q = 1'b0;
  reg        css_q   = 1'b1;
  reg        sel_n_q = 1'b1;
  reg  [1:0] mode_q  = 2'b00;
  reg  [7:0] stx_q   = 8'h00;
  reg  [7:0] st;
  wire [7:0] rdata_out;
  wire [7:0] srx;
  wire       sclk_out, sclk_oe_out, mosi_out, mosi_oe_out, miso_out, miso_oe_out;
  wire       rx_irq_out, err_irq_out, m_miso;
  integer    fail_count = 0;
  integer    compares = 0;
  integer    cyc = 0;
  integer    k;
  wire       sclk_w = sclk_oe_out ? sclk_out : bsclk_q;
  wire       mosi_w = mosi_oe_out ? mosi_out : bmosi_q;
  wire       miso_w = miso_oe_out ? miso_out : m_miso;
  always #25 clk_in = ~clk_in;
  sms_core u_sms_core (.clk_in, .sys_rst_in(rst_q), .addr_in(addr_q), .wr_en_in(wr_q),
    .rd_en_in(rd_q), .wdata_in(wdata_q), .rdata_out, .sclk_in(sclk_w), .sclk_out,
    .sclk_oe_out, .mosi_in(mosi_w), .mosi_out, .mosi_oe_out, .miso_in(miso_w), .miso_out,
    .miso_oe_out, .ss_n_in(css_q), .rx_irq_out, .err_irq_out);
  sms_slave_model u_sms_slave_model (.sclk_in(sclk_w), .mosi_in(mosi_w), .ss_n_in(sel_n_q),
    .clock_polarity_bit_in(mode_q[1]), .clock_phase_bit_in(mode_q[0]), .tx_in(stx_q), .miso_out(m_miso), .rx_out(srx));
  task tally_and_finish;
    begin
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count = fail_count + 1;
      tally_and_finish;
    end
  end
  task chk8(input [7:0] g, input [7:0] e);
    begin
      compares = compares + 1;
      if (g !== e) begin
        fail_count = fail_count + 1;
        $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      addr_q <= a;
      wdata_q <= d;
      wr_q <= 1'b1;
      @(posedge clk_in);
      wr_q <= 1'b0;
      @(posedge clk_in);
    end
  endtask
  // Data lands one edge after the address, so sample at the second edge
  task rd(input [7:0] a, output [7:0] d);
    begin
      addr_q <= a;
      rd_q <= 1'b1;
      @(posedge clk_in);
      rd_q <= 1'b0;
      @(posedge clk_in);
      d = rdata_out;
    end
  endtask
  task rdc(input [7:0] a, input [7:0] m, input [7:0] e);
    reg [7:0] d;
    begin
      rd(a, d);
      chk8(d & m, e);
    end
  endtask
  task t_master(input [1:0] m, input [1:0] r, input [7:0] mb, input [7:0] sb);
    integer n;
    begin
      mode_q <= m;
      css_q <= 1'b1;
      bsclk_q <= m[1];
      stx_q <= sb;
      wr(A_CTL, {3'h0, m, 3'h0});
      wr(A_ST, {6'h00, r});
      wr(A_CTL, {3'h1, m, 3'h2});
      sel_n_q <= 1'b0;
      wr(A_DAT, mb);
      n = 0;
      st = 8'h00;
      while (st[7] !== 1'b1 && n < 1000) begin
        rd(A_ST, st);
        n = n + 1;
      end
      chk8(st & 8'h88, 8'h88);
      rdc(A_DAT, 8'hff, sb);
      chk8(srx, mb);
      rdc(A_ST, 8'h80, 8'h00);
      sel_n_q <= 1'b1;
      @(posedge clk_in);
      $display("master mode %0d rate %0d done", m, r);
    end
  endtask
  task t_overrun;
    integer n;
    begin
      mode_q <= 2'b01;
      bsclk_q <= 1'b0;
      stx_q <= 8'hc3;
      wr(A_CTL, 8'h08);
      wr(A_ST, 8'h41);
      wr(A_CTL, 8'haa);
      sel_n_q <= 1'b0;
      wr(A_DAT, 8'h5a);
      wr(A_DAT, 8'ha5);
      rdc(A_ST, 8'h08, 8'h00);
      n = 0;
      while (srx !== 8'ha5 && n < 400) begin
        @(posedge clk_in);
        n = n + 1;
      end
      repeat (8) @(posedge clk_in);
      chk8({6'h00, rx_irq_out, err_irq_out}, 8'h03);
      rdc(A_ST, 8'ha0, 8'ha0);
      rdc(A_DAT, 8'hff, 8'hc3);
      rdc(A_ST, 8'ha0, 8'h00);
      chk8({6'h00, rx_irq_out, err_irq_out}, 8'h00);
      sel_n_q <= 1'b1;
      $display("overrun done");
    end
  endtask
  task t_slave;
    integer i;
    reg [7:0] got;
    reg [7:0] pat;
    begin
      pat = 8'h3c;
      bsclk_q <= 1'b0;
      wr(A_CTL, 8'h00);
      wr(A_CTL, 8'h02);
      wr(A_DAT, 8'h96);
      css_q <= 1'b0;
      repeat (3) @(posedge clk_in);
      chk8({6'h00, miso_oe_out, miso_out}, 8'h03);
      // Slave output settles two cycles after a trailing edge
      for (i = 7; i >= 0; i = i - 1) begin
        bmosi_q <= pat[i];
        repeat (3) @(posedge clk_in);
        got[i] = miso_w;
        bsclk_q <= 1'b1;
        repeat (2) @(posedge clk_in);
        bsclk_q <= 1'b0;
      end
      repeat (2) @(posedge clk_in);
      css_q <= 1'b1;
      repeat (4) @(posedge clk_in);
      chk8({7'h00, miso_oe_out}, 8'h00);
      chk8(got, 8'h96);
      rdc(A_ST, 8'h80, 8'h80);
      rdc(A_DAT, 8'hff, pat);
      $display("slave done");
    end
  endtask
  initial begin
    repeat (8) @(posedge clk_in);
    rst_q <= 1'b0;
    @(posedge clk_in);
    rdc(A_CTL, 8'hff, 8'h08);
    rdc(A_ST, 8'hff, 8'h08);
    wr(8'h13, 8'hff);
    rdc(8'h13, 8'hff, 8'h00);
    $display("registers done");
    for (k = 0; k < 4; k = k + 1)
      t_master(k[1:0], k[1:0], 8'h35 + k[7:0], 8'hca - k[7:0]);
    t_overrun;
    t_slave;
    tally_and_finish;
  end
endmodule // sms_core_test

//--- sms_defs.vh
// Register map, field positions and timing constants for the serial block
`ifndef SMS_DEFS_VH
`define SMS_DEFS_VH
`define SMS_ADDR_W        8
`define SMS_ADDR_CTRL     8'h10
`define SMS_ADDR_STAT     8'h11
`define SMS_ADDR_DATA     8'h12
// serial_control fields
`define SMS_CTL_RXIE      7
`define SMS_CTL_MSTR      5
`define SMS_CTL_CLOCK_POLARITY_BIT      4
`define SMS_CTL_CLOCK_PHASE_BIT      3
`define SMS_CTL_ENA       1
`define SMS_CTL_TXIE      0
`define SMS_CTL_RST       8'h08
`define SMS_CTL_MASK      8'hBB
// serial_status_control fields
`define SMS_ST_RXF        7
`define SMS_ST_ERROR_INTERRUPT_ENABLE      6
`define SMS_ST_OVR        5
`define SMS_ST_MODE_FAULT_FLAG       4
`define SMS_ST_TXE        3
`define SMS_ST_MODFEN     2
`define SMS_ST_RATE_HI    1
`define SMS_ST_RATE_LO    0
`define SMS_ST_RST        8'h08
// Rate-select half-bit divisors in bus cycles (bit time 2, 8, 32, 128)
`define SMS_HALF_DIV0     7'h01
`define SMS_HALF_DIV1     7'h04
`define SMS_HALF_DIV2     7'h10
`define SMS_HALF_DIV3     7'h40
`define SMS_BITS          4'h8
`endif

//--- sms_props.sv
// Pin and register-port assertions for the serial core
`timescale 1ns/10ps
`include "sms_defs.vh"
module sms_props #(
  parameter ADDR_W = 8
) (
  input wire              clk_in,
  input wire              sys_rst_in,
  input wire [ADDR_W-1:0] addr_in,
  input wire              wr_en_in,
  input wire [7:0]        rdata_out,
  input wire              sclk_out,
  input wire              sclk_oe_out,
  input wire              mosi_oe_out,
  input wire              miso_oe_out,
  input wire              ss_n_in,
  input wire              rx_irq_out,
  input wire              err_irq_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  roles_excl_a: assert property (!(sclk_oe_out && miso_oe_out))
    else $error("clock and slave data driven together");
  data_excl_a: assert property (!(mosi_oe_out && miso_oe_out))
    else $error("both data lines driven");
  desel_quiet_a: assert property (ss_n_in [*3] |-> !miso_oe_out)
    else $error("slave data driven while deselected");
  release_a: assert property ($rose(ss_n_in) |-> ##[1:3] !miso_oe_out)
    else $error("slave data not released");
  start_delay_a: assert property ((wr_en_in && addr_in == `SMS_ADDR_DATA && sclk_oe_out)
    |-> ##[1:300] $changed(sclk_out))
    else $error("transfer did not start in time");
  unmapped_rd_a: assert property ((addr_in < 8'h10 || addr_in > 8'h12) |=> rdata_out == 8'h00)
    else $error("unmapped read not zero");
  rst_quiet_a: assert property ($fell(sys_rst_in) |-> !sclk_oe_out && !miso_oe_out && !err_irq_out)
    else $error("outputs active after reset");
  rst_irq_a: assert property ($fell(sys_rst_in) |-> !rx_irq_out [*2])
    else $error("interrupt right after reset");
  cover property (wr_en_in && addr_in == `SMS_ADDR_DATA && sclk_oe_out);
  cover property ($rose(miso_oe_out));
  cover property ($rose(rx_irq_out));
  cover property ($rose(err_irq_out));
endmodule // sms_props
bind sms_core sms_props #(.ADDR_W(ADDR_W)) u_sms_props (.clk_in, .sys_rst_in, .addr_in,
  .wr_en_in, .rdata_out, .sclk_out, .sclk_oe_out, .mosi_oe_out, .miso_oe_out, .ss_n_in,
  .rx_irq_out, .err_irq_out);

//--- sms_rate_gen.v
// Free-running master baud-rate generator producing half-bit enable pulses
`timescale 1ns/10ps
`include "sms_defs.vh"
module sms_rate_gen #(
  parameter CNT_W = 7
) (
  input  wire       clk_in,
  input  wire       sys_rst_in,
  input  wire       run_in,
  input  wire [1:0] rate_in,
  output reg        half_tick_out
);
  reg [CNT_W-1:0] cnt_q;
  reg [CNT_W-1:0] lim;

  always @* begin
    case (rate_in)
      2'b00:   lim = `SMS_HALF_DIV0;
      2'b01:   lim = `SMS_HALF_DIV1;
      2'b10:   lim = `SMS_HALF_DIV2;
      default: lim = `SMS_HALF_DIV3;
    endcase
  end

  // Runs only with master and enable both set, to save power
  always @(posedge clk_in) begin
    if (sys_rst_in || !run_in) begin
      cnt_q         <= {CNT_W{1'b0}};
      half_tick_out <= 1'b0;
    end else if (cnt_q + 1'b1 >= lim) begin
      cnt_q         <= {CNT_W{1'b0}};
      half_tick_out <= 1'b1;
    end else begin
      cnt_q         <= cnt_q + 1'b1;
      half_tick_out <= 1'b0;
    end
  end
endmodule // sms_rate_gen

//--- sms_slave_model.sv
// Behavioural far-side serial slave for master-mode tests
`timescale 1ns/10ps
module sms_slave_model (
  input  wire       sclk_in,
  input  wire       mosi_in,
  input  wire       ss_n_in,
  input  wire       clock_polarity_bit_in,
  input  wire       clock_phase_bit_in,
  input  wire [7:0] tx_in,
  output reg        miso_out,
  output reg  [7:0] rx_out
);
  reg [7:0] sh_q;
  always @(negedge ss_n_in) begin
    sh_q = tx_in;
    if (!clock_phase_bit_in)
      miso_out = tx_in[7];
  end
  // No pull on the line, so show the inverse once released
  always @(posedge ss_n_in) miso_out = ~miso_out;
  always @(sclk_in) begin
    if (!ss_n_in && ((sclk_in ^ clock_polarity_bit_in) ^ clock_phase_bit_in)) begin
      sh_q = {sh_q[6:0], mosi_in};
      rx_out = sh_q;
    end else if (!ss_n_in)
      miso_out = sh_q[7];
  end
endmodule // sms_slave_model
